// *** logic/dramc_pkg.sv ***
// How it works
// - Wait 200 us after power-up first.
// - Eight row strobes after power-up.
// - Address is nine row then nine column.
// - Address held stable at strobe falls.
// - Early write: write enable before column.
// - Hidden refresh keeps column low, cycles row.
// - Refresh every row within 4 ms.
// - Refresh strobes 256 rows on low bits.
// - Row-only refresh keeps column strobe high.
// - Page mode bounded by row low maximum.
package dramc_pkg;
   localparam int CLK_NS = 100;
   localparam int POWERUP_US = 200;
   localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int INIT_STROBES = 8;
   localparam int REFRESH_MS = 4;
   localparam int REFRESH_ROWS = 256;
   // Spacing rounds down so all rows fit inside the period.
   localparam int REFRESH_GAP_CYC = (REFRESH_MS * 1000000 / CLK_NS) / REFRESH_ROWS;
   localparam int ROW_ACCESS_TIME_NS = 150;
   localparam int ROW_ACCESS_CYC = (ROW_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int ROW_TO_COL_DELAY_NS = 30;
   localparam int ROW_TO_COL_CYC = (ROW_TO_COL_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRECHARGE_NS = 100;
   localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
   localparam int OUTPUT_FLOAT_DELAY_NS = 40;
   localparam int OUTPUT_FLOAT_CYC = (OUTPUT_FLOAT_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int ROW_STROBE_MAX_LOW_NS = 10000;
   localparam int ROW_STROBE_MAX_LOW_CYC = ROW_STROBE_MAX_LOW_NS / CLK_NS;
   // Page bursts stop this many cycles early to leave room for the last column cycle.
   localparam int PAGE_MARGIN_CYC = 4;
   localparam int ADDR_W = 9;
   localparam int CELL_W = 18;
   localparam int REF_W = 8;
   localparam int CNT_W = 16;
   typedef enum logic [3:0] {
      DRAMC_POWERUP, DRAMC_INIT, DRAMC_IDLE, DRAMC_ROW, DRAMC_COL, DRAMC_PAGE,
      DRAMC_PRECHARGE, DRAMC_REF_ROW, DRAMC_HIDDEN
   } dramc_state_t;
endpackage

// *** logic/dramc_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module dramc_ctrl #(
   parameter int POWERUP_CYCLES = dramc_pkg::POWERUP_CYC,
   parameter int REFRESH_GAP = dramc_pkg::REFRESH_GAP_CYC
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // User request side.
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_page,
   input wire logic [dramc_pkg::CELL_W-1:0] req_addr,
   input wire logic req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic rsp_rdata,
   output logic init_done,
   // Memory pins.
   output logic row_strobe_n,
   output logic col_strobe_n,
   output logic write_en_n,
   output logic [dramc_pkg::ADDR_W-1:0] mux_address_bus,
   output logic data_input_pin,
   input wire logic data_out_pin
);
   dramc_pkg::dramc_state_t state, next_state;
   logic [dramc_pkg::CNT_W-1:0] wait_cnt;
   logic [dramc_pkg::CNT_W-1:0] ref_cnt;
   logic [dramc_pkg::CNT_W-1:0] row_low_cnt;
   logic [3:0] init_cnt;
   logic [dramc_pkg::REF_W-1:0] ref_row;
   logic [dramc_pkg::CELL_W-1:0] cur_addr;
   logic cur_write;
   logic cur_page;
   logic ref_due;
   logic read_held;

   // Row portion is the upper nine bits of the cell address, column the lower.
   function automatic logic [dramc_pkg::ADDR_W-1:0] row_of(input logic [dramc_pkg::CELL_W-1:0] a);
      row_of = a[dramc_pkg::CELL_W-1:dramc_pkg::ADDR_W];
   endfunction
   function automatic logic [dramc_pkg::ADDR_W-1:0] col_of(input logic [dramc_pkg::CELL_W-1:0] a);
      col_of = a[dramc_pkg::ADDR_W-1:0];
   endfunction

   // Handshake and decisions.
   wire wait_done = (wait_cnt == '0);
   wire page_ok = (row_low_cnt
      < dramc_pkg::CNT_W'(dramc_pkg::ROW_STROBE_MAX_LOW_CYC - dramc_pkg::PAGE_MARGIN_CYC));
   wire page_hit = req_valid && req_page && (row_of(req_addr) == row_of(cur_addr)) && page_ok;
   wire refresh_row_cyc = (state == dramc_pkg::DRAMC_INIT) || (state == dramc_pkg::DRAMC_REF_ROW)
      || (state == dramc_pkg::DRAMC_HIDDEN);
   assign req_ready = ((state == dramc_pkg::DRAMC_IDLE) && !ref_due)
      || ((state == dramc_pkg::DRAMC_PAGE) && page_hit && !ref_due);

   // Next state logic; refresh takes priority over new requests.
   always_comb begin
      next_state = state;
      case (state)
         dramc_pkg::DRAMC_POWERUP: if (wait_done) next_state = dramc_pkg::DRAMC_PRECHARGE;
         dramc_pkg::DRAMC_INIT: if (wait_done) next_state = dramc_pkg::DRAMC_PRECHARGE;
         dramc_pkg::DRAMC_IDLE: begin
            if (ref_due) begin
               next_state = dramc_pkg::DRAMC_REF_ROW;
            end else if (req_valid) begin
               next_state = dramc_pkg::DRAMC_ROW;
            end
         end
         dramc_pkg::DRAMC_ROW: if (wait_done) next_state = dramc_pkg::DRAMC_COL;
         dramc_pkg::DRAMC_COL: begin
            if (wait_done) begin
               if (ref_due && !cur_write) begin
                  next_state = dramc_pkg::DRAMC_HIDDEN;
               end else if (cur_page) begin
                  next_state = dramc_pkg::DRAMC_PAGE;
               end else begin
                  next_state = dramc_pkg::DRAMC_PRECHARGE;
               end
            end
         end
         dramc_pkg::DRAMC_PAGE: begin
            // The open row waits for a following hit until a request that misses, refresh or the row limit ends it.
            if (page_hit && !ref_due) begin
               next_state = dramc_pkg::DRAMC_COL;
            end else if (req_valid || ref_due || !page_ok) begin
               next_state = dramc_pkg::DRAMC_PRECHARGE;
            end
         end
         dramc_pkg::DRAMC_PRECHARGE: begin
            if (wait_done) begin
               next_state = (init_cnt < 4'(dramc_pkg::INIT_STROBES)) ? dramc_pkg::DRAMC_INIT
                  : dramc_pkg::DRAMC_IDLE;
            end
         end
         dramc_pkg::DRAMC_REF_ROW: if (wait_done) next_state = dramc_pkg::DRAMC_PRECHARGE;
         dramc_pkg::DRAMC_HIDDEN: if (wait_done) next_state = dramc_pkg::DRAMC_PRECHARGE;
         default: next_state = dramc_pkg::DRAMC_POWERUP;
      endcase
   end

   // Wait counter loaded on each state change with that state's duration.
   logic [dramc_pkg::CNT_W-1:0] next_wait;
   always_comb begin
      next_wait = (wait_cnt == '0) ? '0 : wait_cnt - 1'b1;
      if (next_state != state || (state == dramc_pkg::DRAMC_PAGE)) begin
         case (next_state)
            dramc_pkg::DRAMC_ROW: next_wait = dramc_pkg::CNT_W'(dramc_pkg::ROW_TO_COL_CYC);
            dramc_pkg::DRAMC_COL: next_wait = dramc_pkg::CNT_W'(dramc_pkg::ROW_ACCESS_CYC);
            dramc_pkg::DRAMC_PRECHARGE: next_wait = dramc_pkg::CNT_W'(dramc_pkg::PRECHARGE_CYC);
            dramc_pkg::DRAMC_INIT, dramc_pkg::DRAMC_REF_ROW:
               next_wait = dramc_pkg::CNT_W'(dramc_pkg::ROW_ACCESS_CYC);
            dramc_pkg::DRAMC_HIDDEN:
               next_wait = dramc_pkg::CNT_W'(dramc_pkg::ROW_ACCESS_CYC + dramc_pkg::PRECHARGE_CYC);
            default: next_wait = '0;
         endcase
      end
   end

   localparam logic [dramc_pkg::CNT_W-1:0] CNT_W_POWERUP = dramc_pkg::CNT_W'(POWERUP_CYCLES);

   // State, counters and request capture.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state <= dramc_pkg::DRAMC_POWERUP;
         wait_cnt <= CNT_W_POWERUP;
         init_cnt <= '0;
         cur_addr <= '0;
         cur_write <= 1'b0;
         cur_page <= 1'b0;
      end else begin
         state <= next_state;
         wait_cnt <= next_wait;
         if (state == dramc_pkg::DRAMC_INIT && next_state != state && init_cnt < 4'(dramc_pkg::INIT_STROBES)) begin
            init_cnt <= init_cnt + 1'b1;
         end
         if (req_ready && req_valid) begin
            cur_addr <= req_addr;
            cur_write <= req_write;
            cur_page <= req_page;
         end
      end
   end
   // Refresh interval timer; the pending flag set wins over its clear.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ref_cnt <= '0;
         ref_due <= 1'b0;
         ref_row <= '0;
      end else begin
         ref_cnt <= (ref_cnt >= dramc_pkg::CNT_W'(REFRESH_GAP - 1)) ? '0 : ref_cnt + 1'b1;
         if (ref_cnt >= dramc_pkg::CNT_W'(REFRESH_GAP - 1)) begin
            ref_due <= 1'b1;
         end else if ((state == dramc_pkg::DRAMC_REF_ROW || state == dramc_pkg::DRAMC_HIDDEN)
               && next_state != state) begin
            ref_due <= 1'b0;
         end
         if (refresh_row_cyc && next_state != state) begin
            ref_row <= ref_row + 1'b1;
         end
      end
   end

   // Row low time is tracked so page bursts release the row in time.
   always_ff @(posedge sys_clk) begin
      if (sys_rst || row_strobe_n) begin
         row_low_cnt <= '0;
      end else begin
         row_low_cnt <= row_low_cnt + 1'b1;
      end
   end

   // In page mode the column comes straight from the request being taken.
   wire [dramc_pkg::CELL_W-1:0] cur_addr_sel = (state == dramc_pkg::DRAMC_PAGE) ? req_addr : cur_addr;
   wire write_sel = (state == dramc_pkg::DRAMC_PAGE) ? req_write : cur_write;

   // Pin drive: address changes only while its strobe is not falling.
   logic next_row_n, next_col_n, next_we_n;
   logic [dramc_pkg::ADDR_W-1:0] next_addr;
   always_comb begin
      next_row_n = 1'b0;
      next_col_n = 1'b1;
      next_we_n = 1'b1;
      next_addr = row_of(cur_addr);
      case (next_state)
         dramc_pkg::DRAMC_POWERUP, dramc_pkg::DRAMC_IDLE, dramc_pkg::DRAMC_PRECHARGE: begin
            // The refresh row is put out early so a refresh strobe never falls on a moving address.
            next_row_n = 1'b1;
            next_addr = {1'b0, ref_row};
         end
         dramc_pkg::DRAMC_INIT, dramc_pkg::DRAMC_REF_ROW: next_addr = {1'b0, ref_row};
         dramc_pkg::DRAMC_HIDDEN: begin
            // The row is precharged first and strobed again while the column stays low.
            next_row_n = (state != dramc_pkg::DRAMC_HIDDEN)
               || (wait_cnt > dramc_pkg::CNT_W'(dramc_pkg::ROW_ACCESS_CYC + 1));
            next_addr = {1'b0, ref_row};
            next_col_n = 1'b0;
         end
         dramc_pkg::DRAMC_ROW: begin
            // The row address leads the strobe by one cycle so it is settled at the fall.
            next_row_n = (state != dramc_pkg::DRAMC_ROW);
            next_addr = row_of(next_state != state ? req_addr : cur_addr);
         end
         dramc_pkg::DRAMC_COL: begin
            next_addr = col_of(state == dramc_pkg::DRAMC_COL ? cur_addr : cur_addr_sel);
            next_col_n = (state != dramc_pkg::DRAMC_COL);
            next_we_n = !(state == dramc_pkg::DRAMC_COL ? cur_write : write_sel);
         end
         dramc_pkg::DRAMC_PAGE: next_addr = col_of(cur_addr);
         default: next_row_n = 1'b1;
      endcase
   end
   // Pin registers; write enable settles one cycle before the column fall.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         row_strobe_n <= 1'b1;
         col_strobe_n <= 1'b1;
         write_en_n <= 1'b1;
         mux_address_bus <= '0;
         data_input_pin <= 1'b0;
      end else begin
         row_strobe_n <= next_row_n;
         col_strobe_n <= next_col_n;
         write_en_n <= next_we_n;
         mux_address_bus <= next_addr;
         if (req_ready && req_valid) begin
            data_input_pin <= req_wdata;
         end
      end
   end

   // Read data is sampled at the end of the column phase, unaltered.
   assign read_held = (state == dramc_pkg::DRAMC_COL) && wait_done && !cur_write;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 1'b0;
         init_done <= 1'b0;
      end else begin
         rsp_valid <= read_held;
         if (read_held) begin
            rsp_rdata <= data_out_pin;
         end
         init_done <= (init_cnt >= 4'(dramc_pkg::INIT_STROBES));
      end
   end
endmodule // dramc_ctrl
`default_nettype wire

// *** test/dramc_dram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dramc_dram_model (
   // Strobes and address.
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   input wire logic [8:0] mux_address_bus,
   // Data pins.
   input wire logic data_input_pin,
   output logic data_out_pin
);
   logic mem [0:262143];
   logic [8:0] row, col;
   logic early = 1'b0;
   logic ok = 1'b0;
   logic rd = 1'b0;
   // Row latch takes the address at the very fall, so an address that moves with the strobe is caught.
   always @(negedge row_strobe_n) row = mux_address_bus;
   // Column latch; early write stores data here, reads ignore the data pin.
   always @(negedge col_strobe_n) begin
      col = mux_address_bus;
      early = !write_en_n;
      if (early) mem[{row, col}] = data_input_pin;
      rd = mem[{row, col}];
      ok <= #75 1'b1;
   end
   // Late write takes data on the write enable fall.
   always @(negedge write_en_n) #1 if (!col_strobe_n) mem[{row, col}] = data_input_pin;
   // Column release turns the output off.
   always @(posedge col_strobe_n) ok = 1'b0;
   // A floating output shows the inverse level, so a late sample never passes by luck.
   assign data_out_pin = (ok && !col_strobe_n && !early) ? rd : ~rd;
endmodule // dramc_dram_model
`default_nettype wire

// *** test/dramc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dramc_checker #(
   parameter int POWERUP_CYCLES = 20,
   parameter int REFRESH_GAP = 40
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Observed outputs.
   input wire logic rsp_valid,
   input wire logic init_done,
   input wire logic row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_en_n,
   input wire logic [dramc_pkg::ADDR_W-1:0] mux_address_bus
);
   logic [15:0] up_cnt, low_cnt, gap_cnt;
   logic [3:0] fall_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Helper counters saturate or clear so a long run never wraps into a false pass.
   always_ff @(posedge sys_clk) begin
      up_cnt <= sys_rst ? 16'h0 : up_cnt + {15'h0, up_cnt != 16'hFFFF};
      low_cnt <= row_strobe_n ? 16'h0 : low_cnt + 16'h1;
      gap_cnt <= (sys_rst || !init_done || $fell(row_strobe_n)) ? 16'h0 : gap_cnt + 16'h1;
      fall_cnt <= sys_rst ? 4'h0 : fall_cnt + {3'h0, $fell(row_strobe_n) && fall_cnt != 4'hF};
   end
   a_powerup_wait: assert property (up_cnt < POWERUP_CYCLES - 1 |-> row_strobe_n)
      else $error("row strobe in power-up wait");
   a_init_strobes: assert property (init_done |-> fall_cnt >= 4'h8)
      else $error("ready before eight strobes");
   a_col_under_row: assert property ($fell(col_strobe_n) |-> !row_strobe_n)
      else $error("column strobe without row");
   a_col_addr_hold: assert property ($fell(col_strobe_n) |=> $stable(mux_address_bus))
      else $error("column address not held");
   a_row_addr_setup: assert property ($fell(row_strobe_n) |-> $stable(mux_address_bus))
      else $error("address moved at row strobe fall");
   a_col_addr_setup: assert property ($fell(col_strobe_n) |-> $stable(mux_address_bus))
      else $error("address moved at column strobe fall");
   a_read_answer: assert property ($fell(col_strobe_n) && write_en_n |-> ##[1:4] rsp_valid)
      else $error("read answer missing");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   a_row_low_max: assert property (low_cnt <= dramc_pkg::ROW_STROBE_MAX_LOW_CYC)
      else $error("row strobe low too long");
   a_refresh_gap: assert property (gap_cnt <= REFRESH_GAP + 2 * dramc_pkg::ROW_STROBE_MAX_LOW_CYC)
      else $error("refresh overdue");
endmodule // dramc_checker
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_page = 1'b0;
   logic req_wdata = 1'b0;
   logic [17:0] req_addr = 18'h0;
   logic req_ready, rsp_valid, rsp_rdata, init_done, row_strobe_n, col_strobe_n, write_en_n;
   logic data_input_pin, data_out_pin;
   logic [8:0] mux_address_bus;
   logic [17:0] tab [4] = '{18'h00000, 18'h3FFFF, 18'h3FE00, 18'h001FF};
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   // System clock at 10 MHz.
   always #50 sys_clk = ~sys_clk;
   dramc_ctrl #(.POWERUP_CYCLES(20), .REFRESH_GAP(40)) dramc_ctrl_inst (.sys_clk, .sys_rst, .req_valid,
      .req_write, .req_page, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .init_done,
      .row_strobe_n, .col_strobe_n, .write_en_n, .mux_address_bus, .data_input_pin, .data_out_pin);
   dramc_dram_model dramc_dram_model_inst (.row_strobe_n, .col_strobe_n, .write_en_n, .mux_address_bus,
      .data_input_pin, .data_out_pin);
   task automatic report_and_stop;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // A hang counts as a mismatch and still reaches the report.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One request held until taken; a read waits a bounded time for its answer.
   task automatic access(input logic wr, input logic pg, input logic [17:0] a, input logic d, output logic q);
      int k;
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_write = wr;
      req_page = pg;
      req_addr = a;
      req_wdata = d;
      #1;
      for (k = 0; k < 500 && req_ready !== 1'b1; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      req_valid = 1'b0;
      for (k = 0; k < 20 && !wr && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
      q = (rsp_valid === 1'b1) ? rsp_rdata : 1'bx;
   endtask
   task automatic t_init;
      int k;
      for (k = 0; k < 500 && init_done !== 1'b1; k++) @(negedge sys_clk);
      chk(18'(init_done), 18'h1);
   endtask
   // Corner addresses catch swapped or shifted row and column halves.
   task automatic t_single;
      logic q;
      for (int i = 0; i < 4; i++) access(1'b1, 1'b0, tab[i], i[0], q);
      for (int i = 0; i < 4; i++) begin
         access(1'b0, 1'b0, tab[i], 1'b0, q);
         chk(18'(q), 18'(i[0]));
      end
   endtask
   task automatic t_page;
      logic q;
      for (int i = 0; i < 4; i++) access(1'b1, i < 3, {9'h0AB, 9'(i)}, i[1], q);
      for (int i = 0; i < 4; i++) begin
         access(1'b0, i < 3, {9'h0AB, 9'(i)}, 1'b0, q);
         chk(18'(q), 18'(i[1]));
      end
   endtask
   // Idle stretch: row-only strobes with column high, rows in sequence.
   task automatic t_refresh;
      logic last = 1'b1;
      logic [7:0] nxt = 8'h0;
      int n = 0;
      repeat (130) begin
         @(negedge sys_clk);
         if (last && !row_strobe_n) begin
            chk(18'(col_strobe_n), 18'h1);
            if (n > 0) chk(18'(mux_address_bus[7:0]), 18'(nxt));
            nxt = mux_address_bus[7:0] + 8'h1;
            n++;
         end
         last = row_strobe_n;
      end
      chk(18'(n >= 3), 18'h1);
   endtask
   // Mid-run reset quiets the pins, start-up repeats and stored data survives.
   task automatic t_reset;
      logic q;
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk(18'({row_strobe_n, col_strobe_n, write_en_n}), 18'h7);
      sys_rst = 1'b0;
      t_init();
      access(1'b0, 1'b0, tab[1], 1'b0, q);
      chk(18'(q), 18'h1);
   endtask
   // Six cycles of reset, then the scenarios in turn.
   initial begin
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_init();
      t_single();
      t_page();
      t_refresh();
      t_reset();
      report_and_stop();
   end
endmodule // tb_top
bind dramc_ctrl dramc_checker #(.POWERUP_CYCLES(POWERUP_CYCLES), .REFRESH_GAP(REFRESH_GAP)) dramc_checker_inst (
   .sys_clk, .sys_rst, .rsp_valid, .init_done, .row_strobe_n, .col_strobe_n, .write_en_n, .mux_address_bus);
`default_nettype wire
